// ### hdl/stp_cfg.svh
// constants for the servo target/position command block
// assumes a single 20 MHz servo clock domain
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
`define STP_CMD_WRITE_IMM 8'h0B
`define STP_CMD_READ_REG 8'h0C
`define STP_CMD_ZERO_TARGET 8'h90
`define STP_CMD_ZERO_TGT_POS 8'h91
`define STP_CMD_TGT_TO_POS 8'h92
`define STP_SRC_TRAJ 2'h0
`define STP_SRC_STEP 2'h1
`define STP_SRC_INPUT 2'h2
`define STP_REG_TARGET 8'h00
`define STP_REG_POSITION 8'h01
`endif

// ### hdl/stp_pkg.sv
// types for the servo target/position command block
// assumes stp_cfg.svh supplies the numeric constants
package stp_pkg;
    typedef enum logic [2:0] {
        STP_OP_NONE,
        STP_OP_TGT_TO_POS,
        STP_OP_ZERO_TGT,
        STP_OP_ZERO_BOTH,
        STP_OP_WRITE,
        STP_OP_READ
    } stp_op_t;
endpackage

// ### hdl/stp_decode.sv
// command number decoder
// assumes the command word is stable while cmd_valid is high
`timescale 1ns/1ns
`include "stp_cfg.svh"
module stp_decode
    import stp_pkg::*;
(
    input wire logic [7:0] cmd_num,
    input wire logic cmd_alt,
    output stp_op_t op
);
    // one number may carry several commands; cmd_alt picks the alternate use
    always_comb begin
        op = STP_OP_NONE;
        case (cmd_num)
            `STP_CMD_TGT_TO_POS: op = STP_OP_TGT_TO_POS;
            `STP_CMD_ZERO_TARGET: op = STP_OP_ZERO_TGT;
            `STP_CMD_ZERO_TGT_POS: op = STP_OP_ZERO_BOTH;
            `STP_CMD_WRITE_IMM: op = cmd_alt ? STP_OP_NONE : STP_OP_WRITE;
            `STP_CMD_READ_REG: op = cmd_alt ? STP_OP_NONE : STP_OP_READ;
            default: op = STP_OP_NONE;
        endcase
    end
endmodule

// ### hdl/stp_core.sv
// target and position register keeper with command execution
// assumes the host presents one command per cmd_valid pulse, all on sys_clk
// assumes sources and position feedback come from logic on the same clock
`timescale 1ns/1ns
`include "stp_cfg.svh"

// Overview of operation
// - target-to-position command loads target with the present position register value
// - zero-target command moves target minus position into position and clears target on the same edge
// - zero-target-and-position command clears both target and position
// - target follows at most one selected source: trajectory, step-direction or input mode
// - servo loop input is target; position error is target minus position
// - one command number may carry several commands, told apart by alternate use
// - number 11 is immediate register write, number 12 is register read
module stp_core
    import stp_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_num,
    input wire logic cmd_alt,
    input wire logic [7:0] cmd_reg,
    input wire logic [WIDTH-1:0] cmd_data,
    input wire logic [1:0] target_src,
    input wire logic traj_valid,
    input wire logic [WIDTH-1:0] traj_target,
    input wire logic step_valid,
    input wire logic [WIDTH-1:0] step_target,
    input wire logic input_valid,
    input wire logic [WIDTH-1:0] input_target,
    input wire logic pos_valid,
    input wire logic [WIDTH-1:0] pos_meas,
    output logic ack,
    output logic rsp_valid,
    output logic [WIDTH-1:0] rsp_data,
    output logic [WIDTH-1:0] target,
    output logic [WIDTH-1:0] position,
    output logic [WIDTH-1:0] pos_error
);
    // the subtractor and the host word format are only planned for 8 to 64 bits
    if (WIDTH < 8 || WIDTH > 64) begin : g_width_check
        $error("stp_core: WIDTH must lie between 8 and 64");
    end

    ////////////////////////////////////////////////////////////////////////
    stp_op_t op;
    logic [WIDTH-1:0] target_q;
    logic [WIDTH-1:0] target_d;
    logic [WIDTH-1:0] position_q;
    logic [WIDTH-1:0] position_d;
    logic [WIDTH-1:0] pos_error_q;
    logic [WIDTH-1:0] pos_error_d;
    logic ack_q;
    logic ack_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic [WIDTH-1:0] rsp_data_q;
    logic [WIDTH-1:0] rsp_data_d;
    logic src_valid;
    logic [WIDTH-1:0] src_value;
    logic do_copy;
    logic do_zero_tgt;
    logic do_zero_both;
    logic do_write;
    logic do_read;

    ////////////////////////////////////////////////////////////////////////
    // register select decode, shared by the write and the read paths
    function automatic logic sel_is_target(input logic [7:0] sel);
        return sel == `STP_REG_TARGET;
    endfunction

    function automatic logic sel_is_position(input logic [7:0] sel);
        return sel == `STP_REG_POSITION;
    endfunction

    // position error, shared by zero-target and the servo loop output
    function automatic logic [WIDTH-1:0] err_of(
        input logic [WIDTH-1:0] tgt,
        input logic [WIDTH-1:0] pos
    );
        return tgt - pos;
    endfunction

    stp_decode u_dec (
        .cmd_num(cmd_num),
        .cmd_alt(cmd_alt),
        .op(op)
    );

    // single selected source, others ignored
    always_comb begin
        case (target_src)
            `STP_SRC_TRAJ: begin
                src_valid = traj_valid;
                src_value = traj_target;
            end
            `STP_SRC_STEP: begin
                src_valid = step_valid;
                src_value = step_target;
            end
            `STP_SRC_INPUT: begin
                src_valid = input_valid;
                src_value = input_target;
            end
            default: begin
                src_valid = 1'b0;
                src_value = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // one strobe per executed command; unknown numbers and alternate use of 11 or 12 raise none
    always_comb begin
        do_copy = 1'b0;
        do_zero_tgt = 1'b0;
        do_zero_both = 1'b0;
        do_write = 1'b0;
        do_read = 1'b0;
        if (cmd_valid) begin
            case (op)
                STP_OP_TGT_TO_POS: begin
                    do_copy = 1'b1;
                end
                STP_OP_ZERO_TGT: begin
                    do_zero_tgt = 1'b1;
                end
                STP_OP_ZERO_BOTH: begin
                    do_zero_both = 1'b1;
                end
                STP_OP_WRITE: begin
                    do_write = 1'b1;
                end
                STP_OP_READ: begin
                    do_read = 1'b1;
                end
                default: begin
                    do_copy = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a command wins over a source update in the same cycle, so a copy or
    // clear from the host is never lost to a trajectory step landing alongside
    always_comb begin
        target_d = target_q;
        if (src_valid) begin
            target_d = src_value;
        end
        if (do_copy) begin
            target_d = position_q;
        end
        if (do_zero_tgt || do_zero_both) begin
            target_d = '0;
        end
        if (do_write && sel_is_target(cmd_reg)) begin
            target_d = cmd_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            target_q <= '0;
        end else begin
            target_q <= target_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // same priority; a feedback sample in a zeroing cycle is dropped and
    // the next servo sample loads pos_meas unchanged over the zeroed value
    always_comb begin
        position_d = position_q;
        if (pos_valid) begin
            position_d = pos_meas;
        end
        if (do_zero_tgt) begin
            position_d = err_of(target_q, position_q);
        end
        if (do_zero_both) begin
            position_d = '0;
        end
        if (do_write && sel_is_position(cmd_reg)) begin
            position_d = cmd_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            position_q <= '0;
        end else begin
            position_q <= position_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // built from the next values so the error changes on the same edge as its operands
    always_comb begin
        pos_error_d = err_of(target_d, position_d);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pos_error_q <= '0;
        end else begin
            pos_error_q <= pos_error_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acknowledge for every executed non-read command, data only on a read
    always_comb begin
        ack_d = do_copy || do_zero_tgt || do_zero_both || do_write;
        rsp_valid_d = do_read;
        rsp_data_d = rsp_data_q;
        if (do_read) begin
            rsp_data_d = sel_is_position(cmd_reg) ? position_q : target_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
        end else begin
            ack_q <= ack_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
        end
    end

    assign ack = ack_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign target = target_q;
    assign position = position_q;
    assign pos_error = pos_error_q;
endmodule

// ### tb/stp_core_assertions.sv
// port assertions for stp_core
// assumes bind below
`timescale 1ns/1ns
module stp_core_chk #(parameter int WIDTH = 32) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_num,
    input wire logic cmd_alt,
    input wire logic [1:0] target_src,
    input wire logic traj_valid,
    input wire logic [WIDTH-1:0] traj_target,
    input wire logic ack,
    input wire logic rsp_valid,
    input wire logic [WIDTH-1:0] target,
    input wire logic [WIDTH-1:0] position,
    input wire logic [WIDTH-1:0] pos_error
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    tgt_copy_a: assert property (cmd_valid && cmd_num == 8'h92 |=>
        target == $past(position)) else $error("target not copied from position");
    zero_tgt_a: assert property (cmd_valid && cmd_num == 8'h90 |=>
        target == '0 && position == $past(pos_error)) else $error("zero target wrong");
    zero_both_a: assert property (cmd_valid && cmd_num == 8'h91 |=>
        target == '0 && position == '0) else $error("zero both wrong");
    src_traj_a: assert property (!cmd_valid && traj_valid && target_src == 2'h0 |=>
        target == $past(traj_target)) else $error("bad source");
    err_diff_a: assert property (pos_error == target - position) else $error("bad error");
    alt_skip_a: assert property (cmd_valid && cmd_alt && cmd_num == 8'h0B |=>
        !ack) else $error("alt acked");
    rd_answer_a: assert property (cmd_valid && !cmd_alt && cmd_num == 8'h0C |=>
        rsp_valid && !ack) else $error("bad read");
    ack_only_a: assert property (cmd_valid && cmd_num inside {8'h90, 8'h91, 8'h92} |=>
        ack && !rsp_valid) else $error("bad ack");
endmodule
bind stp_core stp_core_chk #(.WIDTH(WIDTH)) chk (.*);

// ### tb/stp_host.sv
// host model: one command per call
// assumes the block samples on rising sys_clk
`timescale 1ns/1ns
module stp_host (
    input wire logic sys_clk,
    input wire logic ack,
    output logic cmd_valid,
    output logic [7:0] cmd_num,
    output logic [31:0] cmd_data
);
    logic got_ack;
    initial begin
        cmd_valid = 1'b0;
        cmd_num = 8'h00;
        cmd_data = 32'h0000_0000;
    end
    task send(input logic [7:0] n, input logic [31:0] d);
        @(negedge sys_clk);
        {cmd_num, cmd_data, cmd_valid} = {n, d, 1'b1};
        @(negedge sys_clk);
        cmd_valid = 0;
        cmd_data = ~d;
        got_ack = ack;
    endtask
endmodule

// ### tb/stp_core_tb.sv
// bench for stp_core
// assumes host model stp_host
`timescale 1ns/1ns
module stp_core_tb;
    logic sys_clk = 0, sys_rst = 1, cmd_alt = 0, step_valid = 0, input_valid = 0;
    logic traj_valid = 0, pos_valid = 0, cmd_valid, ack, rsp_valid;
    logic [1:0] target_src = 0;
    logic [7:0] cmd_num, cmd_reg = 0;
    logic [31:0] traj_target = 0, step_target = 0, input_target = 0, pos_meas = 0;
    logic [31:0] cmd_data, rsp_data, target, position, pos_error;
    int errors = 0, total_checks = 0;
    always #25 sys_clk = ~sys_clk;
    stp_host h (.sys_clk(sys_clk), .ack(ack), .cmd_valid(cmd_valid), .cmd_num(cmd_num),
        .cmd_data(cmd_data));
    stp_core dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .cmd_valid(cmd_valid),
        .cmd_num(cmd_num),
        .cmd_alt(cmd_alt),
        .cmd_reg(cmd_reg),
        .cmd_data(cmd_data),
        .target_src(target_src),
        .traj_valid(traj_valid),
        .traj_target(traj_target),
        .step_valid(step_valid),
        .step_target(step_target),
        .input_valid(input_valid),
        .input_target(input_target),
        .pos_valid(pos_valid),
        .pos_meas(pos_meas),
        .ack(ack),
        .rsp_valid(rsp_valid),
        .rsp_data(rsp_data),
        .target(target),
        .position(position),
        .pos_error(pos_error)
    );
    task chk(input string s, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask
    task feed(input logic [1:0] s);
        target_src = s;
        {traj_target, step_target, input_target, pos_meas} = {32'h1F4, 32'h1F5, 32'h1F6, 32'h64};
        {traj_valid, step_valid, input_valid, pos_valid} = 4'hF;
        @(negedge sys_clk);
        {traj_valid, step_valid, input_valid, pos_valid} = 4'h0;
    endtask
    task t_move;
        for (int s = 0; s < 3; s++) begin
            feed(2'(s));
            chk("target", 32'h1F4 + s, target);
        end
        h.send(8'h92, 0);
        chk("target", 32'h64, target);
        chk("ack", 1, 32'(h.got_ack));
        chk("rsp_valid", 0, 32'(rsp_valid));
        feed(0);
        chk("pos_error", 32'h190, pos_error);
        h.send(8'h90, 0);
        chk("ack", 1, 32'(h.got_ack));
        chk("position", 32'h190, position);
        chk("target", 0, target);
        feed(0);
        h.send(8'h91, 0);
        chk("position", 0, position | target);
        chk("pos_error", 0, pos_error);
    endtask
    task t_regs;
        h.send(8'h0B, 32'h7B);
        chk("ack", 1, 32'(h.got_ack));
        chk("target", 32'h7B, target);
        cmd_alt = 1;
        h.send(8'h0B, 32'h11);
        chk("ack", 0, 32'(h.got_ack));
        chk("target", 32'h7B, target);
        cmd_alt = 0;
        cmd_reg = 8'h01;
        h.send(8'h0B, 32'h2A);
        chk("position", 32'h2A, position);
        h.send(8'h0C, 0);
        chk("rsp_valid", 1, 32'(rsp_valid));
        chk("ack", 0, 32'(h.got_ack));
        chk("rsp_data", 32'h2A, rsp_data);
        cmd_reg = 8'h00;
        h.send(8'h0C, 0);
        chk("rsp_data", 32'h7B, rsp_data);
    endtask
    task t_reset;
        sys_rst = 1;
        @(negedge sys_clk);
        sys_rst = 0;
        chk("pos_error", 0, pos_error);
        chk("target", 0, target | position);
        chk("rsp_data", 0, rsp_data);
        feed(0);
        chk("target", 32'h1F4, target);
    endtask
    task complete_run;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge sys_clk);
        sys_rst = 0;
        @(negedge sys_clk);
        t_move;
        t_regs;
        t_reset;
        complete_run;
    end
endmodule
